// >>> hw/adc_ctrl_pkg.sv
// Purpose: shared constants for the converter control block
// Assumes: APB word addressing, byte address is four times the index
// Notes:   one Tosc equals one pclk period
package adc_ctrl_pkg;

	// register indices and byte addresses
	localparam logic [7:0] IDX_CTRL_A   = 8'h14;
	localparam logic [7:0] IDX_CTRL_B   = 8'h15;
	localparam logic [7:0] IDX_RES_LO   = 8'h16;
	localparam logic [7:0] IDX_RES_HI   = 8'h17;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h18;
	localparam logic [7:0] IDX_IRQ_EN   = 8'h19;
	localparam logic [7:0] IDX_IRQ_CLR  = 8'h1A;
	localparam logic [7:0] ADDR_CTRL_A   = 8'(IDX_CTRL_A * 4);
	localparam logic [7:0] ADDR_CTRL_B   = 8'(IDX_CTRL_B * 4);
	localparam logic [7:0] ADDR_RES_LO   = 8'(IDX_RES_LO * 4);
	localparam logic [7:0] ADDR_RES_HI   = 8'(IDX_RES_HI * 4);
	localparam logic [7:0] ADDR_IRQ_STAT = 8'(IDX_IRQ_STAT * 4);
	localparam logic [7:0] ADDR_IRQ_EN   = 8'(IDX_IRQ_EN * 4);
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'(IDX_IRQ_CLR * 4);

	// field positions, masks and reset values
	localparam int unsigned CA_ON      = 0;
	localparam int unsigned CA_GO      = 2;
	localparam int unsigned CA_CHAN    = 4;
	localparam int unsigned CB_PCFG    = 0;
	localparam int unsigned CB_FMT     = 5;
	localparam int unsigned CB_CLK     = 6;
	localparam logic [7:0]  CA_MASK    = 8'hF5;
	localparam logic [7:0]  CB_MASK    = 8'hEF;
	localparam logic [7:0]  CA_RESET   = 8'h00;
	localparam logic [7:0]  CB_RESET   = 8'h00;
	localparam logic [1:0]  IRQ_RESET  = 2'h0;
	localparam int unsigned IRQ_DONE   = 0;
	localparam int unsigned IRQ_ABORT  = 1;

	// conversion clock select codes and divide ratios
	localparam logic [1:0]  CLK_OSC8   = 2'h0;
	localparam logic [1:0]  CLK_OSC32  = 2'h1;
	localparam logic [1:0]  CLK_OSC64  = 2'h2;
	localparam logic [1:0]  CLK_RC     = 2'h3;
	localparam logic [6:0]  DIV_OSC8   = 7'h08;
	localparam logic [6:0]  DIV_OSC32  = 7'h20;
	localparam logic [6:0]  DIV_OSC64  = 7'h40;

	// sequence lengths in conversion-bit periods and clocks
	localparam logic [3:0]  CONV_TADS  = 4'hC;
	localparam logic [3:0]  ABORT_TADS = 4'h2;
	localparam logic [3:0]  INSTR_TOSC = 4'h4;
	localparam logic [9:0]  SAR_MSB    = 10'h200;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_DELAY   = 4'h2,
		ST_CONV    = 4'h4,
		ST_RECOVER = 4'h8
	} conv_state_type;

endpackage

// >>> hw/tad_tick_gen.sv
// Purpose: conversion-bit period tick from oscillator or RC source
// Assumes: rc_osc is asynchronous to pclk
// Notes:   counter restarts whenever run is low
`timescale 1ns/1ps
module tad_tick_gen (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] clk_sel,
	input  wire logic       run,
	input  wire logic       rc_osc,
	output logic            tick
);

	logic [6:0] div_q;
	logic [2:0] rc_sync_q;
	logic [6:0] ratio;

	////////////////////////////////////////////////////////////////////
	// ratio decode for the oscillator-derived periods
	always_comb begin
		case (clk_sel)
			adc_ctrl_pkg::CLK_OSC8:  ratio = adc_ctrl_pkg::DIV_OSC8;
			adc_ctrl_pkg::CLK_OSC32: ratio = adc_ctrl_pkg::DIV_OSC32;
			default:                 ratio = adc_ctrl_pkg::DIV_OSC64;
		endcase
	end

	// rc source: two stages, third only for the edge compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_sync_q <= 3'h0;
		end else begin
			rc_sync_q <= {rc_sync_q[1:0], rc_osc};
		end
	end

	// divider runs only while a sequence needs it, saving power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 7'h00;
		end else if (!run || div_q == ratio - 7'h01) begin
			div_q <= 7'h00;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end

	assign tick = run && ((clk_sel == adc_ctrl_pkg::CLK_RC)
		? (rc_sync_q[1] && !rc_sync_q[2])
		: (div_q == ratio - 7'h01));

endmodule // tad_tick_gen

// >>> hw/adc_ctrl.sv
// Purpose: control of a 10-bit successive-approximation converter
// Assumes: APB slave, zero wait; sleep_active from the core, same clock
// Notes:   result bytes have no reset by design
`timescale 1ns/1ps
module adc_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_active,
	input  wire logic        comp_in,
	input  wire logic        rc_osc,
	output logic             irq,
	output logic             wake_req,
	output logic             sample_en,
	output logic             analog_power_en,
	output logic      [9:0]  dac_code,
	output logic      [3:0]  channel_select,
	output logic      [3:0]  port_config_select
);

	adc_ctrl_pkg::conv_state_type state_q;
	logic [7:0]  ctrl_a_q;
	logic [7:0]  ctrl_b_q;
	logic [7:0]  res_lo_q;
	logic [7:0]  res_hi_q;
	logic [1:0]  irq_stat_q;
	logic [1:0]  irq_en_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic [3:0]  tad_cnt_q;
	logic [3:0]  dly_q;
	logic [9:0]  sar_q;
	logic [1:0]  comp_sync_q;
	logic        tick;
	logic        wr;
	logic        hit;
	logic [7:0]  rdata;
	logic        conv_on;
	logic        go;
	logic        rc_mode;
	logic        fmt_right;
	logic        start;
	logic        sw_abort;
	logic        halt_abort;
	logic        busy;
	logic        abort;
	logic        done;
	logic [9:0]  bit_m;

	// right or left placement of the 10-bit code in 16 bits
	function automatic logic [15:0] justify(input logic [9:0] v,
		input logic right);
		justify = right ? {6'h00, v} : {v, 6'h00};
	endfunction

	assign conv_on   = ctrl_a_q[adc_ctrl_pkg::CA_ON];
	assign go        = ctrl_a_q[adc_ctrl_pkg::CA_GO];
	assign rc_mode   = ctrl_b_q[adc_ctrl_pkg::CB_CLK +: 2]
		== adc_ctrl_pkg::CLK_RC;
	assign fmt_right = ctrl_b_q[adc_ctrl_pkg::CB_FMT];
	assign busy      = state_q == adc_ctrl_pkg::ST_DELAY
		|| state_q == adc_ctrl_pkg::ST_CONV;

	////////////////////////////////////////////////////////////////////
	// bus decode; pready is always high, no wait states
	assign wr      = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	always_comb begin
		hit   = 1'b1;
		rdata = 8'h00;
		case (paddr)
			adc_ctrl_pkg::ADDR_CTRL_A:   rdata = ctrl_a_q;
			adc_ctrl_pkg::ADDR_CTRL_B:   rdata = ctrl_b_q;
			adc_ctrl_pkg::ADDR_RES_LO:   rdata = res_lo_q;
			adc_ctrl_pkg::ADDR_RES_HI:   rdata = res_hi_q;
			adc_ctrl_pkg::ADDR_IRQ_STAT: rdata = {6'h00, irq_stat_q};
			adc_ctrl_pkg::ADDR_IRQ_EN:   rdata = {6'h00, irq_en_q};
			adc_ctrl_pkg::ADDR_IRQ_CLR:  rdata = 8'h00;
			default:                     hit = 1'b0;
		endcase
	end

	// read data captured in setup so it stands during the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q  <= {24'h00_0000, rdata};
			pslverr_q <= !hit;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequence triggers
	// start only with the converter already on
	assign start = wr && paddr == adc_ctrl_pkg::ADDR_CTRL_A
		&& pwdata[adc_ctrl_pkg::CA_GO] && conv_on && !go
		&& state_q == adc_ctrl_pkg::ST_IDLE;
	// clearing start or the on bit mid-conversion
	assign sw_abort = busy && wr && paddr == adc_ctrl_pkg::ADDR_CTRL_A
		&& !(pwdata[adc_ctrl_pkg::CA_GO] && pwdata[adc_ctrl_pkg::CA_ON]);
	// halt without RC clock kills the conversion
	assign halt_abort = sleep_active && !rc_mode;
	assign abort = busy && (sw_abort || halt_abort);
	assign done = state_q == adc_ctrl_pkg::ST_CONV && tick && !abort
		&& tad_cnt_q == adc_ctrl_pkg::CONV_TADS - 4'h1;

	tad_tick_gen u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_sel (ctrl_b_q[adc_ctrl_pkg::CB_CLK +: 2]),
		.run     (state_q == adc_ctrl_pkg::ST_CONV
			|| state_q == adc_ctrl_pkg::ST_RECOVER),
		.rc_osc  (rc_osc),
		.tick    (tick)
	);

	// comparator is analog, so it is synchronised before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_sync_q <= 2'h0;
		end else begin
			comp_sync_q <= {comp_sync_q[0], comp_in};
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequence state machine
	// reset returns to idle, any conversion dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= adc_ctrl_pkg::ST_IDLE;
			tad_cnt_q <= 4'h0;
			dly_q     <= 4'h0;
		end else begin
			case (state_q)
				adc_ctrl_pkg::ST_IDLE: begin
					tad_cnt_q <= 4'h0;
					dly_q     <= 4'h0;
					// RC clock leaves room for the halt
					if (start && rc_mode) begin
						state_q <= adc_ctrl_pkg::ST_DELAY;
					end else if (start) begin
						state_q <= adc_ctrl_pkg::ST_CONV;
					end
				end
				adc_ctrl_pkg::ST_DELAY: begin
					dly_q <= dly_q + 4'h1;
					if (abort) begin
						state_q <= adc_ctrl_pkg::ST_RECOVER;
					end else if (dly_q == adc_ctrl_pkg::INSTR_TOSC - 4'h1) begin
						state_q <= adc_ctrl_pkg::ST_CONV;
					end
				end
				adc_ctrl_pkg::ST_CONV: begin
					if (abort) begin
						state_q   <= adc_ctrl_pkg::ST_RECOVER;
						tad_cnt_q <= 4'h0;
					end else if (done) begin
						state_q <= adc_ctrl_pkg::ST_IDLE;
					end else if (tick) begin
						tad_cnt_q <= tad_cnt_q + 4'h1;
					end
				end
				adc_ctrl_pkg::ST_RECOVER: begin
					// two bit periods before acquiring again
					if (tick && tad_cnt_q == adc_ctrl_pkg::ABORT_TADS - 4'h1) begin
						state_q <= adc_ctrl_pkg::ST_IDLE;
					end else if (tick) begin
						tad_cnt_q <= tad_cnt_q + 4'h1;
					end
				end
				default: state_q <= adc_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	// successive approximation: one bit resolved per period
	assign bit_m = adc_ctrl_pkg::SAR_MSB >> (tad_cnt_q - 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sar_q <= 10'h000;
		end else if (state_q == adc_ctrl_pkg::ST_CONV && tick) begin
			if (tad_cnt_q == 4'h0) begin
				sar_q <= adc_ctrl_pkg::SAR_MSB;
			end else if (tad_cnt_q <= 4'hA) begin
				sar_q <= (sar_q & ~bit_m) | (comp_sync_q[1] ? bit_m : 10'h000)
					| (bit_m >> 1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_q <= adc_ctrl_pkg::CA_RESET;
			ctrl_b_q <= adc_ctrl_pkg::CB_RESET;
		end else begin
			if (wr && paddr == adc_ctrl_pkg::ADDR_CTRL_B && !busy) begin
				ctrl_b_q <= pwdata[7:0] & adc_ctrl_pkg::CB_MASK;
			end
			if (wr && paddr == adc_ctrl_pkg::ADDR_CTRL_A) begin
				ctrl_a_q <= (pwdata[7:0] & adc_ctrl_pkg::CA_MASK
					& ~(8'h01 << adc_ctrl_pkg::CA_GO))
					| ((start || (go && !abort && !done
					&& pwdata[adc_ctrl_pkg::CA_GO]))
					? (8'h01 << adc_ctrl_pkg::CA_GO) : 8'h00);
			end else if (done || abort) begin
				// hardware clears start at the end
				ctrl_a_q[adc_ctrl_pkg::CA_GO] <= 1'b0;
			end
		end
	end

	// no reset term: power-up value unknown, kept otherwise
	always_ff @(posedge pclk) begin
		if (done) begin
			{res_hi_q, res_lo_q} <= justify(sar_q, fmt_right);
		end else if (wr && !conv_on && !busy) begin
			// plain storage while the converter is off
			if (paddr == adc_ctrl_pkg::ADDR_RES_LO) begin
				res_lo_q <= pwdata[7:0];
			end
			if (paddr == adc_ctrl_pkg::ADDR_RES_HI) begin
				res_hi_q <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt status; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= adc_ctrl_pkg::IRQ_RESET;
			irq_en_q   <= adc_ctrl_pkg::IRQ_RESET;
		end else begin
			if (wr && paddr == adc_ctrl_pkg::ADDR_IRQ_EN) begin
				irq_en_q <= pwdata[1:0];
			end
			irq_stat_q <= (irq_stat_q
				& ~((wr && paddr == adc_ctrl_pkg::ADDR_IRQ_CLR)
				? pwdata[1:0] : 2'h0))
				| {abort, done};
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);
	// wake only through an enabled done flag
	assign wake_req = sleep_active
		&& irq_stat_q[adc_ctrl_pkg::IRQ_DONE]
		&& irq_en_q[adc_ctrl_pkg::IRQ_DONE];

	// analog off in non-RC halt even though on reads set
	assign analog_power_en    = conv_on && !halt_abort;
	assign sample_en          = analog_power_en
		&& state_q == adc_ctrl_pkg::ST_IDLE;
	assign dac_code           = sar_q;
	assign channel_select     = ctrl_a_q[adc_ctrl_pkg::CA_CHAN +: 4];
	assign port_config_select = ctrl_b_q[adc_ctrl_pkg::CB_PCFG +: 4];

	////////////////////////////////////////////////////////////////////
	// checks
	// own tick count, kept apart from the sequencer counter
	logic [3:0] chk_ticks_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_ticks_q <= 4'h0;
		end else if (state_q != adc_ctrl_pkg::ST_CONV) begin
			chk_ticks_q <= 4'h0;
		end else if (tick && chk_ticks_q != 4'hF) begin
			chk_ticks_q <= chk_ticks_q + 4'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_DONE_LOAD: assert property (
		done |=> {res_hi_q, res_lo_q} == justify($past(sar_q), fmt_right))
		else $error("result not loaded at done");
	AST_RIGHT_ZERO: assert property (
		done && fmt_right |=> res_hi_q[7:2] == 6'h00)
		else $error("right justify upper bits not zero");
	AST_LEFT_ZERO: assert property (
		done && !fmt_right |=> res_lo_q[5:0] == 6'h00)
		else $error("left justify lower bits not zero");
	AST_RC_DELAY: assert property (
		state_q == adc_ctrl_pkg::ST_IDLE && start && rc_mode
		|=> state_q == adc_ctrl_pkg::ST_DELAY [*4])
		else $error("rc start delay wrong");
	AST_GO_CLEARS: assert property (
		done |=> !go && irq_stat_q[adc_ctrl_pkg::IRQ_DONE])
		else $error("done did not clear start and set flag");
	AST_HALT_ABORT: assert property (
		busy && sleep_active && !rc_mode
		|=> state_q == adc_ctrl_pkg::ST_RECOVER && !analog_power_en)
		else $error("halt did not abort");
	AST_OFF_NO_START: assert property (
		!conv_on && state_q == adc_ctrl_pkg::ST_IDLE
		|=> state_q == adc_ctrl_pkg::ST_IDLE)
		else $error("start while off");
	AST_UNIMPL_ZERO: assert property (
		(ctrl_a_q & ~adc_ctrl_pkg::CA_MASK) == 8'h00
		&& (ctrl_b_q & ~adc_ctrl_pkg::CB_MASK) == 8'h00)
		else $error("unimplemented bit set");
	AST_SW_ABORT_KEEP: assert property (
		sw_abort |=> $stable({res_hi_q, res_lo_q}) && !go)
		else $error("abort touched result");
	AST_WAKE: assert property (
		sleep_active && done && irq_en_q[adc_ctrl_pkg::IRQ_DONE]
		|=> wake_req)
		else $error("no wake on done");
	AST_TWELVE: assert property (
		done |-> chk_ticks_q == adc_ctrl_pkg::CONV_TADS - 4'h1)
		else $error("conversion length wrong");

	CVR_DONE_RIGHT: cover property (done && fmt_right);
	CVR_RC_SLEEP:   cover property (done && sleep_active && rc_mode);
	CVR_SW_ABORT:   cover property (sw_abort);
	CVR_HALT_ABORT: cover property (busy && halt_abort);

endmodule // adc_ctrl

// >>> sim/analog_core_model.sv
// Purpose: analog input and RC source beside the converter
// Assumes: ideal comparator, one when input is at or above trial code
// Notes:   RC source runs free, unrelated in phase to pclk
`timescale 1ns/1ps
module analog_core_model (
	input  wire logic [9:0] dac_code,
	input  wire logic [9:0] level,
	output logic            comp_in,
	output logic            rc_osc
);
	// no offset or noise, so the result is exactly the level
	assign comp_in = (level >= dac_code);
	// about 74 ns a cycle, never a multiple of the bus clock
	initial begin
		rc_osc = 1'b0;
		forever #37 rc_osc = ~rc_osc;
	end
endmodule // analog_core_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: APB master, one idle cycle between transfers
// Notes:   status polled over the bus, so times are lower bounds
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] A_CA = adc_ctrl_pkg::ADDR_CTRL_A;
	localparam logic [7:0] A_CB = adc_ctrl_pkg::ADDR_CTRL_B;
	localparam logic [7:0] A_LO = adc_ctrl_pkg::ADDR_RES_LO;
	localparam logic [7:0] A_HI = adc_ctrl_pkg::ADDR_RES_HI;
	localparam logic [7:0] A_ST = adc_ctrl_pkg::ADDR_IRQ_STAT;
	localparam logic [7:0] A_EN = adc_ctrl_pkg::ADDR_IRQ_EN;
	localparam logic [7:0] A_CL = adc_ctrl_pkg::ADDR_IRQ_CLR;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sleep_active;
	logic        comp_in;
	logic        rc_osc;
	logic        irq;
	logic        wake_req;
	logic        sample_en;
	logic        analog_power_en;
	logic [9:0]  dac_code;
	logic [3:0]  chan;
	logic [3:0]  pcfg;
	logic [9:0]  level;
	logic [31:0] rdata;
	logic        rerr;
	logic [15:0] last;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cyc = 0;

	adc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_active(sleep_active),
		.comp_in(comp_in), .rc_osc(rc_osc), .irq(irq),
		.wake_req(wake_req), .sample_en(sample_en),
		.analog_power_en(analog_power_en), .dac_code(dac_code),
		.channel_select(chan), .port_config_select(pcfg));
	analog_core_model model_u (.dac_code(dac_code), .level(level),
		.comp_in(comp_in), .rc_osc(rc_osc));

	////////////////////////////////////////////////////////////////////
	// clock, cycle count and hang guard
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	initial begin
		#400000;
		fail_count++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////
	// one transfer; idle edge after it so psel never toggles in one step
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait limit here: only the watchdog ends a stalled access
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic ck(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		bus(1'b0, a, 8'h00);
		ck(nm, e, rdata);
	endtask
	// bounded poll of the status register
	task automatic wait_stat(input logic [7:0] m);
		int n;
		n = 0;
		bus(1'b0, A_ST, 8'h00);
		while ((rdata[7:0] & m) == 8'h00 && n < 400) begin
			n++;
			bus(1'b0, A_ST, 8'h00);
		end
		// a poll that runs out counts as a mismatch
		ck("stat_flag", {24'h0, m}, {24'h0, rdata[7:0] & m});
	endtask
	function automatic logic [15:0] just(input logic r,
		input logic [9:0] v);
		return r ? {6'h00, v} : {v, 6'h00};
	endfunction

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_basic;
		rd(A_CA, 32'h0, "ctrl_a_reset");
		rd(A_CB, 32'h0, "ctrl_b_reset");
		bus(1'b0, 8'h00, 8'h00);
		ck("unmapped_err", 32'h1, {31'h0, rerr});
		bus(1'b1, A_CB, 8'hFF);
		rd(A_CB, 32'hEF, "ctrl_b_mask");
		ck("port_cfg", 32'hF, {28'h0, pcfg});
		bus(1'b1, A_CA, 8'hFF);
		rd(A_CA, 32'hF1, "ctrl_a_mask");
		ck("channel", 32'hF, {28'h0, chan});
		rd(A_ST, 32'h0, "off_no_start");
		bus(1'b1, A_CA, 8'h00);
		bus(1'b1, A_LO, 8'hA5);
		bus(1'b1, A_HI, 8'h5A);
		rd(A_LO, 32'hA5, "gpr_lo");
		rd(A_HI, 32'h5A, "gpr_hi");
	endtask
	// full conversion; s halts the core right after the start write
	task automatic t_conv(input logic [1:0] c, input logic f,
		input logic [9:0] v, input int d, input logic s, input logic en);
		int t0;
		logic ok;
		last = just(f, v);
		level <= v;
		bus(1'b1, A_EN, {7'h00, en});
		bus(1'b1, A_CB, {c, f, 5'h00});
		bus(1'b1, A_CA, 8'h01);
		bus(1'b1, A_CA, 8'h05);
		t0 = cyc;
		if (s) sleep_active <= 1'b1;
		wait_stat(8'h01);
		ok = (cyc - t0) >= 12 * d;
		ck("conv_time", 32'h1, {31'h0, ok});
		ck("wake", {31'h0, s & en}, {31'h0, wake_req});
		ck("irq", {31'h0, en}, {31'h0, irq});
		rd(A_LO, {24'h0, last[7:0]}, "res_lo");
		rd(A_HI, {24'h0, last[15:8]}, "res_hi");
		rd(A_CA, 32'h01, "start_clear");
		sleep_active <= 1'b0;
		bus(1'b1, A_CL, 8'h03);
		ck("irq_clr", 32'h0, {31'h0, irq});
	endtask
	// abort by clearing start, or by a halt with an oscillator clock
	task automatic t_abort(input logic s);
		bus(1'b1, A_EN, 8'h02);
		bus(1'b1, A_CB, 8'h80);
		bus(1'b1, A_CA, 8'h05);
		if (s) sleep_active <= 1'b1;
		else bus(1'b1, A_CA, 8'h01);
		wait_stat(8'h02);
		ck("irq_abort", 32'h1, {31'h0, irq});
		ck("power", {31'h0, ~s}, {31'h0, analog_power_en});
		rd(A_CA, 32'h01, "on_kept");
		rd(A_LO, {24'h0, last[7:0]}, "lo_kept");
		rd(A_HI, {24'h0, last[15:8]}, "hi_kept");
		sleep_active <= 1'b0;
		bus(1'b1, A_CL, 8'h03);
		ck("irq_abort_clr", 32'h0, {31'h0, irq});
		if (!s) begin
			ck("recover", 32'h0, {31'h0, sample_en});
			repeat (140) @(posedge pclk);
			ck("reacquire", 32'h1, {31'h0, sample_en});
		end
	endtask
	// reset in mid-conversion keeps the result bytes
	task automatic t_rst;
		// recovery must end first, or the start would be refused
		repeat (140) @(posedge pclk);
		bus(1'b1, A_CA, 8'h05);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		ck("power_rst", 32'h0, {31'h0, analog_power_en});
		rd(A_CA, 32'h0, "ctrl_a_rst");
		rd(A_CB, 32'h0, "ctrl_b_rst");
		rd(A_ST, 32'h0, "stat_rst");
		rd(A_LO, {24'h0, last[7:0]}, "lo_rst");
		rd(A_HI, {24'h0, last[15:8]}, "hi_rst");
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence; oscillator clocks alternate the format bit
	initial begin
		logic [9:0] lv [3];
		int         dv [3];
		lv = '{10'h2B7, 10'h001, 10'h3FF};
		dv = '{8, 32, 64};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep_active = 1'b0;
		level = 10'h000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_basic();
		for (int i = 0; i < 3; i++) begin
			t_conv(2'(i), i[0], lv[i], dv[i], 1'b0, 1'b1);
		end
		t_conv(2'h3, 1'b1, 10'h155, 0, 1'b1, 1'b1);
		t_conv(2'h3, 1'b0, 10'h2AA, 0, 1'b1, 1'b0);
		t_abort(1'b0);
		t_abort(1'b1);
		t_rst();
		complete_run();
	end
endmodule // tb_top
